// *** core/qwce_map.vh ***
// constants of the quad wiper command engine
`ifndef QWCE_MAP_VH
`define QWCE_MAP_VH

// ==========================================================
// clock and programming time
`define QWCE_CLK_MHZ 100
`define QWCE_PROG_TIME_US 5000

// ==========================================================
// address byte
// type code value is arbitrary
`define QWCE_TYPE_CODE 4'hA
`define QWCE_BYTE_BITS 4'h8

// ==========================================================
// instruction opcodes, bits [7:4] of the instruction byte
`define QWCE_OP_ALL_LOAD 4'h1
`define QWCE_OP_STEP 4'h2
`define QWCE_OP_ALL_SAVE 4'h8
`define QWCE_OP_RD_WIPER 4'h9
`define QWCE_OP_WR_WIPER 4'hA
`define QWCE_OP_RD_STORE 4'hB
`define QWCE_OP_WR_STORE 4'hC
`define QWCE_OP_LOAD 4'hD
`define QWCE_OP_SAVE 4'hE

// ==========================================================
// instruction byte fields
`define QWCE_OP_MSB 7
`define QWCE_OP_LSB 4
`define QWCE_SET_MSB 3
`define QWCE_SET_LSB 2
`define QWCE_POT_MSB 1
`define QWCE_POT_LSB 0

// ==========================================================
// wiper limits and reset values
`define QWCE_TAP_MAX 6'h3F
`define QWCE_TAP_MIN 6'h00
`define QWCE_NV_INIT 6'h20
`define QWCE_WIPER_RST 6'h00

`endif

// *** core/qwce_engine.v ***
// command engine of a quad 64-tap potentiometer behind a two-wire slave port
// Operation
// - first byte upper four bits must equal device type code, else ignore
// - first byte lower four bits must match the four address straps
// - write is address, instruction, data bytes, each acknowledged, then stop
// - instruction: opcode top four bits, setting select, pot select lowest
// - setting select 00..11 picks stored register zero..three
// - stored-register command starts programming at stop; ignore master meanwhile
// - programming of a stored register completes within 5 ms
// - address polled while busy is not acknowledged, acknowledged when done
// - write-protect low: address and instruction acked, stored-register data nacked, never programs
// - write-protect falling during programming does not disturb it
// - four 6-bit wiper registers, each decoded to one of 64 taps
// - at power-up each wiper loads stored register zero of its pot
// - four 6-bit stored registers per pot, readable and writable
// - opcode 1001 returns chosen wiper in third byte
// - opcode 1010 writes data byte into chosen wiper
// - opcode 1011 returns chosen stored register in third byte
// - opcode 1100 programs data byte into chosen stored register
// - opcode 1101 copies chosen stored register into its wiper
// - opcode 1110 copies wiper into chosen stored register, non-volatile
// - opcode 0001 copies each pot's selected stored register into its own wiper, all four at once
// - opcode 1000 saves all four wipers to selected stored registers
// - opcode 0010 enables single-step of chosen wiper
// - each clock high with data high steps up, data low steps down
// - every stored-register write or copy programs after stop while write-protect is high
// - read sends eight bits, continues on master ack, else waits stop
`timescale 1ns/1ps
`default_nettype none
`include "qwce_map.vh"

module qwce_engine #(
  parameter integer PROG_CYCLES = `QWCE_PROG_TIME_US * `QWCE_CLK_MHZ,
  parameter [3:0] DEV_TYPE = `QWCE_TYPE_CODE // arbitrary value
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // two-wire bus
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  // straps and protection
  input wire [3:0] address_strap_inputs,
  input wire wp_n_in,
  // wiper state
  output reg [23:0] wiper_position_q,
  output reg [255:0] tap_select_q,
  output reg prog_busy_q
);

  // ==========================================================
  // states
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_INSTR = 4'h2;
  localparam [3:0] ST_DATA = 4'h3;
  localparam [3:0] ST_ACK = 4'h4;
  localparam [3:0] ST_TX = 4'h5;
  localparam [3:0] ST_TXACK = 4'h6;
  localparam [3:0] ST_STEP = 4'h7;
  localparam [3:0] ST_WAIT = 4'h8;
  localparam integer PROG_LAST_I = PROG_CYCLES - 1;
  // 20-bit timer covers the 5 ms default at 100 MHz
  localparam [19:0] PROG_LAST = PROG_LAST_I[19:0];

  // ==========================================================
  // instruction legality
  function legal_instr;
    input [7:0] ins;
    begin
      case (ins[`QWCE_OP_MSB:`QWCE_OP_LSB])
        `QWCE_OP_RD_WIPER, `QWCE_OP_WR_WIPER, `QWCE_OP_STEP:
          legal_instr = (ins[`QWCE_SET_MSB:`QWCE_SET_LSB] == 2'b00);
        `QWCE_OP_RD_STORE, `QWCE_OP_WR_STORE, `QWCE_OP_LOAD, `QWCE_OP_SAVE:
          legal_instr = 1'b1;
        `QWCE_OP_ALL_LOAD, `QWCE_OP_ALL_SAVE:
          legal_instr = (ins[`QWCE_POT_MSB:`QWCE_POT_LSB] == 2'b00);
        default:
          legal_instr = 1'b0;
      endcase
    end
  endfunction

  // ==========================================================
  // input synchronisers
  reg scl_m_q, scl_s_q, scl_p_q;
  reg sda_m_q, sda_s_q, sda_p_q;
  reg [3:0] strap_m_q, strap_s_q;
  reg wpn_m_q, wpn_s_q;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
      strap_m_q <= 4'h0;
      strap_s_q <= 4'h0;
      wpn_m_q <= 1'b0;
      wpn_s_q <= 1'b0;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
      strap_m_q <= address_strap_inputs;
      strap_s_q <= strap_m_q;
      wpn_m_q <= wp_n_in;
      wpn_s_q <= wpn_m_q;
    end
  end

  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // ==========================================================
  // engine state
  reg [3:0] st_q, nxt_q, cnt_q;
  reg [7:0] sh_q, ins_q, tx_q;
  reg mack_q, recall_q;
  reg pend_q;
  reg [3:0] pmask_q;
  reg [1:0] psel_q;
  reg [23:0] pdat_q;
  reg [19:0] pcnt_q;
  reg [5:0] wiper_q [0:3];
  reg [5:0] stored_q [0:15];
  integer i;

  wire [1:0] pot = ins_q[`QWCE_POT_MSB:`QWCE_POT_LSB];
  wire [1:0] set = ins_q[`QWCE_SET_MSB:`QWCE_SET_LSB];
  wire [1:0] sh_pot = sh_q[`QWCE_POT_MSB:`QWCE_POT_LSB];
  wire [1:0] sh_set = sh_q[`QWCE_SET_MSB:`QWCE_SET_LSB];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ins_q <= 8'h00;
      tx_q <= 8'h00;
      mack_q <= 1'b0;
      recall_q <= 1'b1;
      pend_q <= 1'b0;
      pmask_q <= 4'h0;
      psel_q <= 2'b00;
      pdat_q <= 24'h000000;
      pcnt_q <= 20'h00000;
      prog_busy_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_out_q <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        wiper_q[i] <= `QWCE_WIPER_RST;
      // stand-in for blank memory; a real array would keep its contents
      for (i = 0; i < 16; i = i + 1)
        stored_q[i] <= `QWCE_NV_INIT;
    end else begin
      sda_out_q <= 1'b0;
      recall_q <= 1'b0;
      if (recall_q) begin
        for (i = 0; i < 4; i = i + 1)
          wiper_q[i] <= stored_q[i * 4];
      end
      // programming timer; protect pin is ignored once it runs
      if (prog_busy_q) begin
        if (pcnt_q == PROG_LAST) begin
          prog_busy_q <= 1'b0;
          for (i = 0; i < 4; i = i + 1)
            if (pmask_q[i])
              stored_q[i * 4 + psel_q] <= pdat_q[i * 6 +: 6];
        end else begin
          pcnt_q <= pcnt_q + 20'h00001;
        end
      end
      if (start_det) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_det) begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
        pend_q <= 1'b0;
        if (pend_q && wpn_s_q && !prog_busy_q) begin
          prog_busy_q <= 1'b1;
          pcnt_q <= 20'h00000;
        end
      end else begin
        case (st_q)
          ST_ADDR, ST_INSTR, ST_DATA: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == `QWCE_BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                // busy device stays silent so the master can poll
                if (sh_q[7:4] == DEV_TYPE && sh_q[3:0] == strap_s_q
                    && !prog_busy_q) begin
                  sda_oe_q <= 1'b1;
                  st_q <= ST_ACK;
                  nxt_q <= ST_INSTR;
                end else begin
                  st_q <= ST_WAIT;
                end
              end else if (st_q == ST_INSTR) begin
                if (!legal_instr(sh_q)) begin
                  st_q <= ST_WAIT;
                end else begin
                  ins_q <= sh_q;
                  sda_oe_q <= 1'b1;
                  st_q <= ST_ACK;
                  nxt_q <= ST_WAIT;
                  case (sh_q[`QWCE_OP_MSB:`QWCE_OP_LSB])
                    `QWCE_OP_RD_WIPER: begin
                      tx_q <= {2'b00, wiper_q[sh_pot]};
                      nxt_q <= ST_TX;
                    end
                    `QWCE_OP_RD_STORE: begin
                      tx_q <= {2'b00, stored_q[{sh_pot, sh_set}]};
                      nxt_q <= ST_TX;
                    end
                    `QWCE_OP_WR_WIPER, `QWCE_OP_WR_STORE:
                      nxt_q <= ST_DATA;
                    `QWCE_OP_LOAD:
                      wiper_q[sh_pot] <= stored_q[{sh_pot, sh_set}];
                    `QWCE_OP_ALL_LOAD: begin
                      for (i = 0; i < 4; i = i + 1)
                        wiper_q[i] <= stored_q[i * 4 + sh_set];
                    end
                    `QWCE_OP_SAVE, `QWCE_OP_ALL_SAVE: begin
                      pend_q <= 1'b1;
                      psel_q <= sh_set;
                      pdat_q <= {wiper_q[3], wiper_q[2], wiper_q[1], wiper_q[0]};
                      if (sh_q[`QWCE_OP_MSB:`QWCE_OP_LSB] == `QWCE_OP_SAVE)
                        pmask_q <= 4'h1 << sh_pot;
                      else
                        pmask_q <= 4'hF;
                    end
                    `QWCE_OP_STEP:
                      nxt_q <= ST_STEP;
                    default:
                      nxt_q <= ST_WAIT;
                  endcase
                end
              end else begin
                st_q <= ST_WAIT;
                if (ins_q[`QWCE_OP_MSB:`QWCE_OP_LSB] == `QWCE_OP_WR_WIPER) begin
                  wiper_q[pot] <= sh_q[5:0];
                  sda_oe_q <= 1'b1;
                  st_q <= ST_ACK;
                  nxt_q <= ST_WAIT;
                end else if (wpn_s_q) begin
                  pend_q <= 1'b1;
                  pmask_q <= 4'h1 << pot;
                  psel_q <= set;
                  pdat_q <= {4{sh_q[5:0]}};
                  sda_oe_q <= 1'b1;
                  st_q <= ST_ACK;
                  nxt_q <= ST_WAIT;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              st_q <= nxt_q;
              cnt_q <= 4'h0;
              if (nxt_q == ST_TX) begin
                sda_oe_q <= ~tx_q[7];
                sh_q <= {tx_q[6:0], 1'b0};
              end else begin
                sda_oe_q <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == `QWCE_BYTE_BITS) begin
                sda_oe_q <= 1'b0;
                st_q <= ST_TXACK;
              end else begin
                sda_oe_q <= ~sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s_q;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (mack_q) begin
                sda_oe_q <= ~tx_q[7];
                sh_q <= {tx_q[6:0], 1'b0};
                st_q <= ST_TX;
              end else begin
                st_q <= ST_WAIT;
              end
            end
          end
          ST_STEP: begin
            if (scl_rise) begin
              if (sda_s_q && wiper_q[pot] != `QWCE_TAP_MAX)
                wiper_q[pot] <= wiper_q[pot] + 6'h01;
              else if (!sda_s_q && wiper_q[pot] != `QWCE_TAP_MIN)
                wiper_q[pot] <= wiper_q[pot] - 6'h01;
            end
          end
          ST_IDLE, ST_WAIT: begin
            sda_oe_q <= 1'b0;
          end
          default: begin
            st_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // wiper outputs and tap decode
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_pot
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          wiper_position_q[g * 6 +: 6] <= 6'h00;
          tap_select_q[g * 64 +: 64] <= 64'h0000000000000000;
        end else begin
          wiper_position_q[g * 6 +: 6] <= wiper_q[g];
          tap_select_q[g * 64 +: 64] <= 64'h0000000000000001 << wiper_q[g];
        end
      end
    end
  endgenerate

  // stored registers are reached only through the bus commands

endmodule // qwce_engine
`default_nettype wire

// *** sim/qwce_master.sv ***
// two-wire bus master model facing the potentiometer engine
`timescale 1ns/1ps
`default_nettype none
module qwce_m (
  // clock
  input wire logic clk,
  // bus lines, pull high means the master pulls data low
  output logic scl,
  output logic pull,
  input wire logic sda
);
  logic [23:0] res;
  event res_ev;
  initial begin
    scl = 1'h1;
    pull = 1'h0;
  end
  // ==========
  // bit timing, quarter of a 160 ns bus period
  task automatic q(input int n = 1);
    repeat (4 * n) @(negedge clk);
  endtask
  task automatic start();
    pull = 1'h0;
    q();
    scl = 1'h1;
    q();
    pull = 1'h1;
    q();
    scl = 1'h0;
    q();
  endtask
  task automatic stop();
    pull = 1'h1;
    q();
    scl = 1'h1;
    q();
    pull = 1'h0;
    q();
  endtask
  // data only moves while the clock is low
  task automatic wbit(input logic b);
    pull = !b;
    q();
    scl = 1'h1;
    q(2);
    scl = 1'h0;
    q();
  endtask
  task automatic rbit(output logic b);
    pull = 1'h0;
    q();
    scl = 1'h1;
    q();
    b = sda;
    q();
    scl = 1'h0;
    q();
  endtask
  // ==========
  // bytes, each result handed to the bench monitor
  task automatic post(input logic [23:0] v);
    res = v;
    ->res_ev;
  endtask
  task automatic wr(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    post({23'h0, !a});
  endtask
  task automatic rd(input logic ack);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    post({16'h0, d});
    wbit(!ack);
  endtask
endmodule // qwce_m
`default_nettype wire

// *** sim/qwce_engine_assertions.sv ***
// port assertions of the quad wiper command engine
`timescale 1ns/1ps
`default_nettype none
`include "qwce_map.vh"
module qwce_checker #(
  parameter integer PROG_CYCLES = `QWCE_PROG_TIME_US * `QWCE_CLK_MHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // bus and protection
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_q,
  input wire logic sda_out_q,
  input wire logic wp_n_in,
  // wiper state
  input wire logic [23:0] wiper_position_q,
  input wire logic [255:0] tap_select_q,
  input wire logic prog_busy_q
);
  // ==========
  // helper counters
  logic [31:0] bcnt_q;
  logic [2:0] up_q;
  always @(posedge ref_clk) begin
    if (sys_rst || !prog_busy_q) begin
      bcnt_q <= 32'h0;
    end else begin
      bcnt_q <= bcnt_q + 32'h1;
    end
  end
  // taps are compared only once recall has settled
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end
  function automatic logic [255:0] hot(input logic [23:0] w);
    hot = 256'h0;
    for (int k = 0; k < 4; k++) hot[64 * k + w[6 * k +: 6]] = 1'h1;
  endfunction
  // ==========
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence held_low;
    sda_oe_q [*8];
  endsequence
  a_ack_hold: assert property ($rose(sda_oe_q) |-> held_low)
    else $error("data pull released too early");
  a_oe_edges: assert property ($changed(sda_oe_q) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed while clock high");
  a_prog_len: assert property ($fell(prog_busy_q) |-> bcnt_q == PROG_CYCLES)
    else $error("programming length wrong");
  a_prog_bound: assert property (prog_busy_q |-> bcnt_q < PROG_CYCLES)
    else $error("programming overran");
  a_busy_quiet: assert property (prog_busy_q |-> !sda_oe_q)
    else $error("answered while programming");
  a_busy_still: assert property (prog_busy_q |=> $stable(wiper_position_q))
    else $error("wiper moved while programming");
  a_prog_stop: assert property ($rose(prog_busy_q) |-> scl_in && sda_in && !$past(sda_in, 6))
    else $error("programming began away from stop");
  a_wp_block: assert property ($rose(prog_busy_q) |-> $past(wp_n_in, 8))
    else $error("programmed while protected");
  a_tap_hot: assert property (up_q == 3'h7 |-> tap_select_q == hot(wiper_position_q))
    else $error("tap decode wrong");
  a_recall: assert property ($fell(sys_rst) |-> ##4 wiper_position_q == {4{`QWCE_NV_INIT}})
    else $error("recall wrong");
  a_out_low: assert property (!sda_out_q)
    else $error("data pin output value not low");
endmodule // qwce_checker
bind qwce_engine qwce_checker #(.PROG_CYCLES(PROG_CYCLES)) u_qwce_checker (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_oe_q(sda_oe_q),
  .sda_out_q(sda_out_q),
  .wp_n_in(wp_n_in),
  .wiper_position_q(wiper_position_q),
  .tap_select_q(tap_select_q),
  .prog_busy_q(prog_busy_q)
);
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the quad wiper command engine
`timescale 1ns/1ps
`default_nettype none
`include "qwce_map.vh"
`define CK(e, a) begin total_checks++; if ((e) !== (a)) begin err_count++; \
  $display("FAIL %0t got %h want %h", $time, a, e); end end
module tb;
  localparam logic [3:0] DT = 4'h3; // arbitrary type code
  logic ref_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic wp_n = 1'h1;
  logic [3:0] strap = 4'h0;
  logic scl, pull, oe, busy;
  wire logic sda = !(pull || oe);
  logic [23:0] wpos;
  logic [7:0] ad, t;
  logic [5:0] wv [4];
  logic [5:0] sv [16];
  logic [23:0] exp_q [$];
  logic [23:0] exp_v;
  logic [31:0] sd = 32'h3A;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 ref_clk = !ref_clk;
  qwce_engine #(.PROG_CYCLES(200), .DEV_TYPE(DT)) u_qwce_engine (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out_q(), .sda_oe_q(oe),
    .address_strap_inputs(strap), .wp_n_in(wp_n), .wiper_position_q(wpos),
    .tap_select_q(), .prog_busy_q(busy));
  qwce_m u_qwce_m (.clk(ref_clk), .scl(scl), .pull(pull), .sda(sda));
  // ==========
  // monitor and verdict
  // pop once, so a mismatch report cannot eat a second note
  always @(u_qwce_m.res_ev) begin
    exp_v = exp_q.pop_front();
    `CK(exp_v, u_qwce_m.res)
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // helpers
  function automatic logic [7:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd[7:0];
  endfunction
  function automatic logic [7:0] ib(input logic [3:0] o, input int s, input int p);
    return {o, s[1:0], p[1:0]};
  endfunction
  task automatic ex(input logic [23:0] v);
    exp_q.push_back(v);
  endtask
  task automatic lk();
    ex({wv[3], wv[2], wv[1], wv[0]});
    @(negedge ref_clk);
    u_qwce_m.post(wpos);
  endtask
  task automatic cmd(input logic [7:0] a, i, input logic [8:0] d, input logic [2:0] ak);
    u_qwce_m.start();
    ex({23'h0, ak[2]});
    u_qwce_m.wr(a);
    if (ak[2]) begin
      ex({23'h0, ak[1]});
      u_qwce_m.wr(i);
    end
    if (ak[1] && d[8]) begin
      ex({23'h0, ak[0]});
      u_qwce_m.wr(d[7:0]);
    end
    u_qwce_m.stop();
  endtask
  task automatic rdc(input logic [7:0] i, input logic [5:0] e);
    u_qwce_m.start();
    ex(24'h1);
    u_qwce_m.wr(ad);
    ex(24'h1);
    u_qwce_m.wr(i);
    ex({18'h0, e});
    u_qwce_m.rd(1'h1);
    ex({18'h0, e});
    u_qwce_m.rd(1'h0);
    u_qwce_m.stop();
  endtask
  task automatic poll(input logic k);
    cmd(ad, 8'h0, 9'h0, {k, 2'h0});
  endtask
  task automatic nvw();
    poll(1'h0);
    wait (busy === 1'h0);
    poll(1'h1);
  endtask
  task automatic stp(input int p, input int n);
    cmd(ad, ib(4'h2, 0, p), 9'h0, 3'h6);
    u_qwce_m.start();
    ex(24'h1);
    u_qwce_m.wr(ad);
    ex(24'h1);
    u_qwce_m.wr(ib(4'h2, 0, p));
    repeat (n) u_qwce_m.wbit(1'h1);
    u_qwce_m.stop();
  endtask
  // ==========
  // scenarios
  localparam logic [7:0] BAD [10] = '{8'h00, 8'h3F, 8'h45, 8'h5A, 8'h66, 8'h7B, 8'hF0,
    8'h94, 8'h11, 8'h24};
  initial begin
    t = rnd();
    strap = t[3:0];
    ad = {DT, strap};
    wv = '{4{`QWCE_NV_INIT}};
    sv = '{16{`QWCE_NV_INIT}};
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'h0;
    repeat (8) @(negedge ref_clk);
    lk();
    cmd({~DT, strap}, 8'hA0, 9'h100, 3'h0);
    cmd({DT, ~strap}, 8'hA0, 9'h100, 3'h0);
    rdc(ib(4'hB, 2, 3), sv[14]);
    for (int p = 0; p < 4; p++) begin
      t = rnd();
      wv[p] = t[5:0];
      cmd(ad, ib(4'hA, 0, p), {1'h1, t}, 3'h7);
      rdc(ib(4'h9, 0, p), wv[p]);
    end
    lk();
    for (int k = 0; k < 4; k++) begin
      t = rnd();
      sv[3 * k + 3] = t[5:0];
      cmd(ad, ib(4'hC, 3 - k, k), {1'h1, t}, 3'h7);
      nvw();
      rdc(ib(4'hB, 3 - k, k), sv[3 * k + 3]);
    end
    wv[1] = sv[6];
    cmd(ad, ib(4'hD, 2, 1), 9'h0, 3'h6);
    lk();
    sv[9] = wv[2];
    cmd(ad, ib(4'hE, 1, 2), 9'h0, 3'h6);
    nvw();
    rdc(ib(4'hB, 1, 2), sv[9]);
    for (int p = 0; p < 4; p++) wv[p] = sv[4 * p + 3];
    cmd(ad, ib(4'h1, 3, 0), 9'h0, 3'h6);
    lk();
    for (int p = 0; p < 4; p++) sv[4 * p] = wv[p];
    cmd(ad, ib(4'h8, 0, 0), 9'h0, 3'h6);
    nvw();
    rdc(ib(4'hB, 0, 0), sv[0]);
    rdc(ib(4'hB, 0, 3), sv[12]);
    cmd(ad, ib(4'hA, 0, 1), 9'h13E, 3'h7);
    cmd(ad, ib(4'hA, 0, 2), 9'h100, 3'h7);
    stp(1, 3);
    stp(2, 0);
    wv[1] = 6'h3E;
    wv[2] = 6'h00;
    lk();
    wp_n = 1'h0;
    cmd(ad, ib(4'hC, 1, 1), 9'h115, 3'h6);
    cmd(ad, ib(4'hE, 0, 1), 9'h0, 3'h6);
    poll(1'h1);
    rdc(ib(4'hB, 1, 1), sv[5]);
    rdc(ib(4'hB, 0, 1), sv[4]);
    wp_n = 1'h1;
    t = rnd();
    sv[5] = t[5:0];
    cmd(ad, ib(4'hC, 1, 1), {1'h1, t}, 3'h7);
    wp_n = 1'h0;
    nvw();
    rdc(ib(4'hB, 1, 1), sv[5]);
    wp_n = 1'h1;
    foreach (BAD[i]) cmd(ad, BAD[i], 9'h100, 3'h4);
    lk();
    repeat (20) @(negedge ref_clk);
    if (exp_q.size() != 0) err_count++;
    summarize();
  end
endmodule // tb
`default_nettype wire
